/* File: src/hts_map.svh */
// register offsets, fields and reset values of the hdlc timeslot mapping block
// assumes an 8-bit register port with byte addresses
`ifndef HTS_MAP_SVH
`define HTS_MAP_SVH
`define HTS_ADDR_W        8
`define HTS_OFF_RX_CTRL   8'h90
`define HTS_OFF_RX_SUPP   8'h91
`define HTS_OFF_TX_CTRL   8'h92
`define HTS_OFF_TX_SUPP   8'h93
`define HTS_BIT_EN        7
`define HTS_BIT_RSVD      6
`define HTS_BIT_MODE      5
`define HTS_CH_MSB        4
`define HTS_CH_LSB        0
`define HTS_CTRL_RST      8'h00
`define HTS_SUPP_RST      8'h00
`define HTS_RD_ZERO       8'h00
`define HTS_CH_BASE       5'h00
`define HTS_CH_COUNT      24
`endif

/* File: src/hts_pkg.sv */
// types of the hdlc timeslot mapping block
// assumes hts_map.svh gives the numbers
package hts_pkg;
  typedef enum logic [1:0] {
    HTS_SRC_FDL    = 2'b01,
    HTS_SRC_TSLOTS = 2'b10
  } hts_src_t;
  typedef enum logic [1:0] {
    HTS_SEL_SINGLE = 2'b01,
    HTS_SEL_BLOCK  = 2'b10
  } hts_sel_t;
endpackage

/* File: src/hts_dir_map.sv */
// one direction: decodes a control and a suppress register into routing
// assumes control and suppress come straight from registers
`include "hts_map.svh"
module hts_dir_map (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             ctrl,
  input  wire logic [7:0]             supp,
  output hts_pkg::hts_src_t           src_r,
  output hts_pkg::hts_sel_t           sel_r,
  output logic [4:0]                  channel_r,
  output logic [`HTS_CH_COUNT-1:0]    slot_map_r,
  output logic [7:0]                  bit_use_r
);
  wire  [`HTS_CH_COUNT-1:0] slot_map_nxt;

  // one-hot timeslot from the channel field, out-of-range gives none
  for (genvar g = 0; g < `HTS_CH_COUNT; g++) begin : g_slot
    assign slot_map_nxt[g] = (ctrl[`HTS_CH_MSB:`HTS_CH_LSB] - `HTS_CH_BASE) == 5'(g);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r      <= hts_pkg::HTS_SRC_FDL;
      sel_r      <= hts_pkg::HTS_SEL_SINGLE;
      channel_r  <= `HTS_CH_BASE;
      slot_map_r <= '0;
      bit_use_r  <= ~`HTS_SUPP_RST;
    end else begin
      src_r      <= ctrl[`HTS_BIT_EN] ? hts_pkg::HTS_SRC_TSLOTS
                                      : hts_pkg::HTS_SRC_FDL;
      sel_r      <= ctrl[`HTS_BIT_MODE] ? hts_pkg::HTS_SEL_BLOCK
                                        : hts_pkg::HTS_SEL_SINGLE;
      channel_r  <= ctrl[`HTS_CH_MSB:`HTS_CH_LSB];
      // single mode only; block mode or a clear enable gives an all-zero slot map
      slot_map_r <= (ctrl[`HTS_BIT_EN] && !ctrl[`HTS_BIT_MODE]) ? slot_map_nxt : '0;
      // bit 7 is the octet msb; a one suppresses that bit
      bit_use_r  <= ~supp;
    end
  end
endmodule

/* File: src/hts_top.sv */
// hdlc timeslot mapping: four registers steering the rx and tx hdlc engines
// assumes a single-cycle register port, read data one cycle after the strobe
//
// Contract
// - receive enable clear routes rx hdlc to the fdl, set routes it to ds0 timeslots.
// - receive mode zero takes one timeslot from the 5-bit field (bit 4 msb), one uses blocks.
// - each receive suppress bit set removes that octet bit from hdlc reception, bit 7 = msb.
// - transmit enable and mode bits act as their receive counterparts for the tx controller.
// - each transmit suppress bit set keeps tx hdlc off that octet bit, bit 7 = msb.
//
// Decided for this implementation: the strobed register port.
`include "hts_map.svh"
module hts_top (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic [`HTS_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  output hts_pkg::hts_src_t            rx_src,
  output hts_pkg::hts_sel_t            rx_sel,
  output logic [4:0]                   rx_channel,
  output logic [`HTS_CH_COUNT-1:0]     rx_slot_map,
  output logic [7:0]                   rx_bit_use,
  output hts_pkg::hts_src_t            tx_src,
  output hts_pkg::hts_sel_t            tx_sel,
  output logic [4:0]                   tx_channel,
  output logic [`HTS_CH_COUNT-1:0]     tx_slot_map,
  output logic [7:0]                   tx_bit_use
);
  logic [7:0] rx_ctrl_r;
  logic [7:0] rx_supp_r;
  logic [7:0] tx_ctrl_r;
  logic [7:0] tx_supp_r;
  logic [7:0] rdata_nxt;

  // register writes; bit 6 is stored as written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl_r <= `HTS_CTRL_RST;
      rx_supp_r <= `HTS_SUPP_RST;
      tx_ctrl_r <= `HTS_CTRL_RST;
      tx_supp_r <= `HTS_SUPP_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `HTS_OFF_RX_CTRL: rx_ctrl_r <= reg_wdata;
        `HTS_OFF_RX_SUPP: rx_supp_r <= reg_wdata;
        `HTS_OFF_TX_CTRL: tx_ctrl_r <= reg_wdata;
        `HTS_OFF_TX_SUPP: tx_supp_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    unique case (reg_addr)
      `HTS_OFF_RX_CTRL: rdata_nxt = rx_ctrl_r;
      `HTS_OFF_RX_SUPP: rdata_nxt = rx_supp_r;
      `HTS_OFF_TX_CTRL: rdata_nxt = tx_ctrl_r;
      `HTS_OFF_TX_SUPP: rdata_nxt = tx_supp_r;
      default:          rdata_nxt = `HTS_RD_ZERO;
    endcase
  end

  // read data stands one cycle per cycle of reg_rd high, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `HTS_RD_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : `HTS_RD_ZERO;
    end
  end

  // receive routing
  hts_dir_map u_rx (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ctrl       (rx_ctrl_r),
    .supp       (rx_supp_r),
    .src_r      (rx_src),
    .sel_r      (rx_sel),
    .channel_r  (rx_channel),
    .slot_map_r (rx_slot_map),
    .bit_use_r  (rx_bit_use)
  );

  // transmit routing
  hts_dir_map u_tx (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ctrl       (tx_ctrl_r),
    .supp       (tx_supp_r),
    .src_r      (tx_src),
    .sel_r      (tx_sel),
    .channel_r  (tx_channel),
    .slot_map_r (tx_slot_map),
    .bit_use_r  (tx_bit_use)
  );
endmodule

/* File: bench/hts_props.sv */
// checker for the hdlc timeslot mapping ports
// assumes it is bound onto hts_top and sees only its ports
`include "hts_map.svh"
module hts_props (
  input logic               ref_clk,
  input logic               rst_n,
  input logic [7:0]         reg_addr,
  input logic [7:0]         reg_wdata,
  input logic               reg_wr,
  input logic               reg_rd,
  input logic [7:0]         reg_rdata,
  input hts_pkg::hts_src_t  rx_src,
  input hts_pkg::hts_sel_t  rx_sel,
  input logic [4:0]         rx_channel,
  input logic [23:0]        rx_slot_map,
  input logic [7:0]         rx_bit_use,
  input hts_pkg::hts_src_t  tx_src,
  input hts_pkg::hts_sel_t  tx_sel,
  input logic [4:0]         tx_channel,
  input logic [23:0]        tx_slot_map,
  input logic [7:0]         tx_bit_use
);
  timeunit 1ns;
  timeprecision 1ns;
  wire w0 = reg_wr && reg_addr == 8'h90;
  wire w1 = reg_wr && reg_addr == 8'h91;
  wire w2 = reg_wr && reg_addr == 8'h92;
  wire w3 = reg_wr && reg_addr == 8'h93;
  wire r_off = reg_rd && (reg_addr < 8'h90 || reg_addr > 8'h93);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rx_route_a: assert property (w0 |-> ##2 rx_src[1] == $past(reg_wdata[7], 2))
    else $error("rx route wrong");
  rx_mode_a: assert property (w0 |-> ##2 rx_sel[1] == $past(reg_wdata[5], 2))
    else $error("rx mode wrong");
  rx_chan_a: assert property (w0 |-> ##2 rx_channel == $past(reg_wdata[4:0], 2))
    else $error("rx channel wrong");
  rx_supp_a: assert property (w1 |-> ##2 rx_bit_use == ~$past(reg_wdata, 2))
    else $error("rx suppress wrong");
  tx_route_a: assert property (w2 |-> ##2 tx_src[1] == $past(reg_wdata[7], 2))
    else $error("tx route wrong");
  tx_supp_a: assert property (w3 |-> ##2 tx_bit_use == ~$past(reg_wdata, 2))
    else $error("tx suppress wrong");
  rx_slot_a: assert property (rx_slot_map == (rx_src[1] && !rx_sel[1] &&
    rx_channel < 5'd24 ? 24'h00_0001 << rx_channel : 24'h00_0000)) else $error("slot map");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  tx_mode_a: assert property (w2 |-> ##2 tx_sel[1] == $past(reg_wdata[5], 2))
    else $error("tx mode wrong");
  tx_chan_a: assert property (w2 |-> ##2 tx_channel == $past(reg_wdata[4:0], 2))
    else $error("tx channel wrong");
  tx_slot_a: assert property (tx_slot_map == (tx_src[1] && !tx_sel[1] &&
    tx_channel < 5'd24 ? 24'h00_0001 << tx_channel : 24'h00_0000)) else $error("tx slot map");
  rd_unmapped_a: assert property (r_off |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind hts_top hts_props u_props (.*);

/* File: bench/test_hdlc_timeslot_mapping.sv */
// self-checking bench for hts_top
// assumes read data one cycle after the strobe
module test_hdlc_timeslot_mapping;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rx_bit_use, tx_bit_use, a, m [4];
  logic [4:0] rx_channel, tx_channel;
  logic [23:0] rx_slot_map, tx_slot_map;
  hts_pkg::hts_src_t rx_src, tx_src;
  hts_pkg::hts_sel_t rx_sel, tx_sel;
  logic [31:0] seed = 32'h0000_51ed;
  int mismatches = 0, n_compared = 0;
  always #2 ref_clk = ~ref_clk;
  hts_top dut (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [23:0] slots(input logic [7:0] c);
    return (c[7] && !c[5] && c[4:0] < 5'd24) ? 24'h00_0001 << c[4:0] : 24'h00_0000;
  endfunction
  task automatic chk(input logic [23:0] s, e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic outs;
    chk({rx_src, rx_sel}, {m[0][7], !m[0][7], m[0][5], !m[0][5]});
    chk(rx_channel, m[0][4:0]);
    chk(rx_slot_map, slots(m[0]));
    chk(rx_bit_use, 8'(~m[1]));
    chk({tx_src, tx_sel, tx_channel}, {m[2][7], !m[2][7], m[2][5], !m[2][5], m[2][4:0]});
    chk(tx_slot_map, slots(m[2]));
    chk(tx_bit_use, 8'(~m[3]));
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a[7:2] == 6'h24) m[a[1:0]] = d;
    @(posedge ref_clk);
    #1 outs();
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    m = '{default: 8'h00};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 outs();
    wr(8'h90, 8'h97);
    wr(8'h90, 8'h98);
    wr(8'h92, 8'hA0);
    wr(8'h8F, 8'hFF);
    rd(8'h94, 8'h00);
    $display("corner cases done");
    repeat (24) begin
      seed = xs(seed);
      a = 8'h90 | seed[1:0];
      wr(a, seed[15:8] & (a[0] ? 8'hFF : 8'hBF));
      rd(a, m[a[1:0]]);
    end
    $display("random traffic done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    m = '{default: 8'h00};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 outs();
    rd(8'h90, 8'h00);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
